// file: sync_ctrl_pkg.sv
// Purpose: shared constants for the multi-device sync control block
// Assumes: one clock domain (clk_sys); register port with one-cycle read latency
// Notes:   offsets are word indices on the plain register port
package sync_ctrl_pkg;
  // register addresses
  localparam logic [3:0] ADDR_MAIN_CTRL  = 4'h0;  // main_control_register
  localparam logic [3:0] ADDR_ALARM_STAT = 4'h1;  // alarm_status_register
  localparam logic [3:0] ADDR_PLL_CTRL   = 4'h2;  // pll_control_register
  localparam logic [3:0] ADDR_SYNC_SEL   = 4'h3;  // sync_select_register
  localparam logic [3:0] ADDR_IRQ_STAT   = 4'h4;
  localparam logic [3:0] ADDR_IRQ_CLR    = 4'h5;
  localparam logic [3:0] ADDR_IRQ_EN     = 4'h6;
  localparam logic [3:0] ADDR_FIFO_OFS   = 4'h7;
  // main control fields
  localparam int MAIN_DUAL_BIT    = 0;  // 1: dual-source mode
  localparam int MAIN_CLKDIV_BIT  = 1;  // clock divider sync enable
  localparam int MAIN_PLL_ENA_BIT = 2;  // 1: pll mode, internal output strobe
  // pll control field
  localparam int PLL_NDIVSYNC_BIT = 0;
  // sync select fields
  localparam int SEL_WR_SYNC_BIT  = 0;  // write reset source: 0 input strobe, 1 sync
  localparam int SEL_CLKDIV_BIT   = 1;  // divider sync source: 0 output strobe, 1 write src
  // alarm / irq bits
  localparam int ALM_COLLIDE      = 0;
  localparam int ALM_ONE_AWAY     = 1;
  localparam int ALM_TWO_AWAY     = 2;
  localparam int EVT_NDIV_SYNC    = 3;
  localparam int EVT_RD_RESET     = 4;
  localparam int EVT_W            = 5;
  // reset values
  localparam logic [7:0] MAIN_RESET    = 8'h03;
  localparam logic [7:0] PLL_RESET     = 8'h00;
  localparam logic [7:0] SEL_RESET     = 8'h00;
  localparam logic [7:0] FIFO_OFS_RST  = 8'h04;
  localparam logic [7:0] ZERO8         = 8'h00;
  // divider defaults
  localparam int FIFO_DEPTH_DEF    = 8;
  localparam int CLKDIV_DEF        = 4;
  localparam int NDIV_DEF          = 8;
endpackage

// file: sync_edge_det.sv
// Purpose: two-flop synchroniser with rising-edge pulse out
// Assumes: input comes from another clock region
// Notes:   first flop feeds only the second flop
`timescale 1ns/1ps
`default_nettype none
module sync_edge_det
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // signal
  input  wire logic async_in,
  output var  logic level_out,
  output var  logic rise_out
);
  logic meta;
  logic prev;

  // metastability filter then edge detect on the settled copy
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      meta      <= 1'b0;
      level_out <= 1'b0;
      prev      <= 1'b0;
      rise_out  <= 1'b0;
    end
    else
    begin
      meta      <= async_in;
      level_out <= meta;
      prev      <= level_out;
      rise_out  <= level_out & ~prev;
    end
  end
endmodule // sync_edge_det
`default_nettype wire

// file: fifo_mem.sv
// Purpose: small sample store for the input fifo
// Assumes: one write and one read port, same clock
// Notes:   read data are registered
`timescale 1ns/1ps
`default_nettype none
module fifo_mem
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
)
(
  // clock
  input  wire logic             clk_sys,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0]    rd_addr,
  output var  logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // storage write
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // registered read, one cycle latency
  always_ff @(posedge clk_sys)
  begin
    rd_data <= mem[rd_addr];
  end
endmodule // fifo_mem
`default_nettype wire

// file: multi_device_sync_control.sv
// Purpose: fifo pointer, clock divider and pll divider sync for multi-device alignment
// Assumes: data side and converter side run on clk_sys; data_valid paces the write side
// Notes:   input_strobe, sync and output_strobe arrive from other parts and are synchronised
// Function
// - input fifo absorbs arrival skew so latency stays constant
// - output strobe sampled to reset read pointer and clock divider
// - pointer alarms shown in a status register and an alarm pin
// - pll mode makes an internal output strobe, no external one needed
// - feedback divider sync enable set: sync rising edge resets feedback divider
// - pll mode needs no timing between sync and input strobe
// - single-source mode resets both pointers from one source
// - single-source read reset is the resampled write reset
// - single-source with pll never uses output strobe for read pointer
// - dual-source: write reset from strobe or sync, read reset from output strobe
// - internal output strobe is the feedback divider output
`timescale 1ns/1ps
`default_nettype none
module multi_device_sync_control
  import sync_ctrl_pkg::*;
#(
  parameter int WIDTH  = 16,
  parameter int DEPTH  = FIFO_DEPTH_DEF,
  parameter int CLKDIV = CLKDIV_DEF,
  parameter int NDIV   = NDIV_DEF
)
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output var  logic [7:0]       reg_rdata,
  // sync pins
  input  wire logic             input_strobe,
  input  wire logic             sync_in,
  input  wire logic             output_strobe,
  // data path
  input  wire logic             data_valid,
  input  wire logic [WIDTH-1:0] data_in,
  output var  logic [WIDTH-1:0] data_out,
  // status outputs
  output var  logic             alarm,
  output var  logic             irq,
  output var  logic             clkdiv_tick,
  output var  logic             pll_strobe
);
  localparam int AW  = $clog2(DEPTH);
  localparam int CW  = $clog2(CLKDIV);
  localparam int NW  = $clog2(NDIV);

  logic [7:0]       main_control_register;
  logic [7:0]       pll_control_register;
  logic [7:0]       sync_select_register;
  logic [7:0]       fifo_offset;
  logic [7:0]       alarm_status_register;
  logic [7:0]       irq_stat;
  logic [7:0]       irq_en;
  logic [7:0]       next_irq_stat;
  logic [7:0]       evt;
  logic             input_strobe_rise;
  logic             sync_rise;
  logic             output_strobe_rise;
  logic             dual_mode;
  logic             pll_mode;
  logic             wr_reset;
  logic             wr_reset_d1;
  logic             wr_reset_d2;
  logic             rd_reset;
  logic             div_src;
  logic             div_reset;
  logic             ndiv_reset;
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    gap;
  logic [CW-1:0]    div_cnt;
  logic [NW-1:0]    ndiv_cnt;
  logic             int_output_strobe;
  logic [WIDTH-1:0] mem_rd;

  // pin synchronisers; edges taken from settled copies only
  // each pin has its own synchroniser, so no phase tie between the pins is needed
  sync_edge_det u_input_strobe
  (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .async_in  (input_strobe),
    .level_out (),
    .rise_out  (input_strobe_rise)
  );
  sync_edge_det u_sync
  (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .async_in  (sync_in),
    .level_out (),
    .rise_out  (sync_rise)
  );
  sync_edge_det u_output_strobe
  (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .async_in  (output_strobe),
    .level_out (),
    .rise_out  (output_strobe_rise)
  );

  assign dual_mode = main_control_register[MAIN_DUAL_BIT];
  assign pll_mode  = main_control_register[MAIN_PLL_ENA_BIT];

  // write pointer reset from input strobe or sync, as selected
  assign wr_reset = sync_select_register[SEL_WR_SYNC_BIT] ? sync_rise : input_strobe_rise;

  // feedback divider reset only while its sync enable is set
  assign ndiv_reset = pll_control_register[PLL_NDIVSYNC_BIT] & sync_rise;

  // pll feedback divider; its terminal count is the internal output strobe
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      ndiv_cnt <= '0;
    else if (ndiv_reset)
      ndiv_cnt <= '0;
    else if (ndiv_cnt == NW'(NDIV - 1))
      ndiv_cnt <= '0;
    else
      ndiv_cnt <= ndiv_cnt + 1'b1;
  end
  assign int_output_strobe = pll_mode && (ndiv_cnt == NW'(NDIV - 1));

  // read reset: dual mode uses a strobe, single mode resamples the write reset
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      wr_reset_d1 <= 1'b0;
      wr_reset_d2 <= 1'b0;
    end
    else
    begin
      wr_reset_d1 <= wr_reset;
      wr_reset_d2 <= wr_reset_d1;
    end
  end
  // single mode never looks at the output strobe for the read side
  assign rd_reset = dual_mode ? (pll_mode ? int_output_strobe : output_strobe_rise)
                              : wr_reset_d2;

  // divider source: output strobe (internal in pll mode) or the write-side source
  assign div_src   = sync_select_register[SEL_CLKDIV_BIT] ? wr_reset
                                                          : (pll_mode ? int_output_strobe : output_strobe_rise);
  assign div_reset = main_control_register[MAIN_CLKDIV_BIT] & div_src;

  // converter clock divider; phase held when sync is disabled
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      div_cnt <= '0;
    else if (div_reset)
      div_cnt <= '0;
    else if (div_cnt == CW'(CLKDIV - 1))
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 1'b1;
  end

  // write pointer; restarts at zero on a write reset
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      wr_ptr <= '0;
    else if (wr_reset)
      wr_ptr <= '0;
    else if (data_valid)
      wr_ptr <= wr_ptr + 1'b1;
  end

  // read pointer starts the programmed offset behind, so skew is absorbed
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      rd_ptr <= '0;
    else if (rd_reset)
      rd_ptr <= AW'(0) - fifo_offset[AW-1:0];
    else if (data_valid)
      rd_ptr <= rd_ptr + 1'b1;
  end

  fifo_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem
  (
    .clk_sys (clk_sys),
    .wr_en   (data_valid),
    .wr_addr (wr_ptr),
    .wr_data (data_in),
    .rd_addr (rd_ptr),
    .rd_data (mem_rd)
  );

  assign gap = wr_ptr - rd_ptr;

  // pointer-distance alarms
  always_comb
  begin
    alarm_status_register = ZERO8;
    alarm_status_register[ALM_COLLIDE]  = (gap == AW'(0));
    alarm_status_register[ALM_ONE_AWAY] = (gap == AW'(1)) || (gap == AW'(DEPTH - 1));
    alarm_status_register[ALM_TWO_AWAY] = (gap == AW'(2)) || (gap == AW'(DEPTH - 2));
  end

  // interrupt events
  always_comb
  begin
    evt = ZERO8;
    evt[ALM_COLLIDE]   = alarm_status_register[ALM_COLLIDE];
    evt[ALM_ONE_AWAY]  = alarm_status_register[ALM_ONE_AWAY];
    evt[ALM_TWO_AWAY]  = alarm_status_register[ALM_TWO_AWAY];
    evt[EVT_NDIV_SYNC] = ndiv_reset;
    evt[EVT_RD_RESET]  = rd_reset;
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_comb
  begin
    next_irq_stat = irq_stat;
    if (reg_wr && reg_addr == ADDR_IRQ_CLR)
      next_irq_stat = irq_stat & ~reg_wdata;
    next_irq_stat = next_irq_stat | evt;
  end

  // status bits stay set until software clears them
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      irq_stat <= ZERO8;
    else
      irq_stat <= next_irq_stat;
  end

  // writable registers
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      main_control_register <= MAIN_RESET;
      pll_control_register  <= PLL_RESET;
      sync_select_register  <= SEL_RESET;
      fifo_offset           <= FIFO_OFS_RST;
      irq_en                <= ZERO8;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_MAIN_CTRL: main_control_register <= reg_wdata;
        ADDR_PLL_CTRL:  pll_control_register  <= reg_wdata;
        ADDR_SYNC_SEL:  sync_select_register  <= reg_wdata;
        ADDR_FIFO_OFS:  fifo_offset           <= reg_wdata;
        ADDR_IRQ_EN:    irq_en                <= reg_wdata;
        default:        ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      reg_rdata <= ZERO8;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_MAIN_CTRL:  reg_rdata <= main_control_register;
        ADDR_ALARM_STAT: reg_rdata <= alarm_status_register;
        ADDR_PLL_CTRL:   reg_rdata <= pll_control_register;
        ADDR_SYNC_SEL:   reg_rdata <= sync_select_register;
        ADDR_IRQ_STAT:   reg_rdata <= irq_stat;
        ADDR_IRQ_EN:     reg_rdata <= irq_en;
        ADDR_FIFO_OFS:   reg_rdata <= fifo_offset;
        default:         reg_rdata <= ZERO8;
      endcase
    end
    else
      reg_rdata <= ZERO8;
  end

  // registered outputs
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      alarm       <= 1'b0;
      irq         <= 1'b0;
      clkdiv_tick <= 1'b0;
      pll_strobe  <= 1'b0;
      data_out    <= '0;
    end
    else
    begin
      alarm       <= |alarm_status_register[ALM_TWO_AWAY:ALM_COLLIDE];
      irq         <= |(next_irq_stat & irq_en);
      clkdiv_tick <= (div_cnt == CW'(CLKDIV - 1));
      pll_strobe  <= int_output_strobe;
      data_out    <= mem_rd;
    end
  end

endmodule // multi_device_sync_control
`default_nettype wire

// file: sync_ctrl_properties.sv
// Purpose: port checks for multi_device_sync_control
// Assumes: one clock, resetn synchronous active low
// Notes:   a few register bits are mirrored from the writes seen at the port
`timescale 1ns/1ps
`default_nettype none
module sync_ctrl_properties
  import sync_ctrl_pkg::*;
#(
  parameter int CLKDIV = CLKDIV_DEF,
  parameter int NDIV   = NDIV_DEF
)
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic       sync_in,
  input wire logic       alarm,
  input wire logic       irq,
  input wire logic       clkdiv_tick,
  input wire logic       pll_strobe
);
  logic [7:0] main_q;
  logic [7:0] en_q;
  logic [3:0] quiet;
  logic [4:0] pgap;
  logic [4:0] tgap;
  logic       pclean;
  logic       tclean;
  wire  logic clr_wr = reg_wr && (reg_addr == ADDR_IRQ_CLR || reg_addr == ADDR_IRQ_EN);
  // mirrors land on the same edge as the design's own registers
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      main_q <= MAIN_RESET;
      en_q   <= ZERO8;
    end
    else if (reg_wr && reg_addr == ADDR_MAIN_CTRL)
      main_q <= reg_wdata;
    else if (reg_wr && reg_addr == ADDR_IRQ_EN)
      en_q <= reg_wdata;
  end
  // cycles since sync was last high, saturating
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || sync_in)
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end
  // strobe gap is only trusted when no sync edge or mode change fell inside it
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      pclean <= 1'b0;
    else if (pll_strobe)
      pclean <= main_q[MAIN_PLL_ENA_BIT] && quiet > 4'h5;
    else
      pclean <= pclean && !sync_in && main_q[MAIN_PLL_ENA_BIT];
    pgap <= pll_strobe ? 5'h01 : pgap + 5'h01;
  end
  // divider gap, trusted only while divider sync stays disabled
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      tclean <= 1'b0;
    else
      tclean <= (clkdiv_tick || tclean) && !main_q[MAIN_CLKDIV_BIT];
    tgap <= clkdiv_tick ? 5'h01 : tgap + 5'h01;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == ZERO8)
    else $error("read data not zero outside a read answer");
  a_unmapped_read_zero: assert property (reg_rd && reg_addr > ADDR_FIFO_OFS |=> !reg_rdata)
    else $error("unmapped read returned nonzero");
  a_alarm_pin_match: assert property ($past(reg_rd && reg_addr == ADDR_ALARM_STAT)
    && alarm == $past(alarm) && alarm == $past(alarm, 2) |-> (|reg_rdata[2:0]) == alarm)
    else $error("alarm pin disagrees with alarm status");
  a_irq_needs_enable: assert property ($rose(irq) |-> en_q != ZERO8)
    else $error("interrupt rose with no enable bit set");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(clr_wr) || $past(clr_wr, 2))
    else $error("interrupt fell without clear or enable write");
  a_tick_one_cycle: assert property (clkdiv_tick |=> !clkdiv_tick)
    else $error("divider tick longer than one cycle");
  a_divider_hold: assert property (clkdiv_tick && tclean |-> int'(tgap) == CLKDIV)
    else $error("divider phase moved while its sync was disabled");
  a_pll_strobe_gap: assert property (pll_strobe && pclean |-> int'(pgap) == NDIV)
    else $error("internal strobe period differs from feedback divide");
  a_pll_off_quiet: assert property (!main_q[MAIN_PLL_ENA_BIT] &&
    !$past(main_q[MAIN_PLL_ENA_BIT]) && !$past(main_q[MAIN_PLL_ENA_BIT], 2) |-> !pll_strobe)
    else $error("internal strobe outside pll mode");
  c_pll_gap: cover property (pll_strobe && pclean);
  c_div_hold: cover property (clkdiv_tick && tclean);
  c_irq_rise: cover property ($rose(irq));
endmodule // sync_ctrl_properties
bind multi_device_sync_control sync_ctrl_properties #(.CLKDIV(CLKDIV), .NDIV(NDIV))
  i_sync_ctrl_properties (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sync_in(sync_in), .alarm(alarm), .irq(irq), .clkdiv_tick(clkdiv_tick),
  .pll_strobe(pll_strobe));
`default_nettype wire

// file: sync_source_model.sv
// Purpose: clock distribution and baseband source driving the sync pins and data
// Assumes: launched on clk_sys, the same domain as the converter clock
// Notes:   each strobe request gives a four-cycle high pulse
`timescale 1ns/1ps
`default_nettype none
module sync_source_model
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // bench requests: bit0 input strobe, bit1 sync, bit2 output strobe
  input  wire logic [2:0]  fire,
  input  wire logic [15:0] data_base,
  // pins toward the device
  output var  logic        input_strobe,
  output var  logic        sync_in,
  output var  logic        output_strobe,
  output var  logic        data_valid,
  output var  logic [15:0] data_in
);
  logic [2:0] pins;
  logic [1:0] cnt [3];
  // strobes fire independently, no timing tie between input strobe and sync
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (!resetn || (pins[i] && cnt[i] == 2'h3))
        pins[i] <= 1'b0;
      else if (fire[i])
        pins[i] <= 1'b1;
      cnt[i] <= pins[i] ? cnt[i] + 2'h1 : 2'h0;
    end
  end
  // a private output strobe per device, from the converter clock domain
  assign {output_strobe, sync_in, input_strobe} = pins;
  // counting stream makes a constant latency visible at the output
  always_ff @(posedge clk_sys)
  begin
    data_valid <= resetn;
    data_in    <= resetn ? data_in + 16'h0001 : data_base;
  end
endmodule // sync_source_model
`default_nettype wire

// file: multi_device_sync_control_tb.sv
// Purpose: self-checking bench for multi_device_sync_control
// Assumes: partner model drives sync pins and data; one gap cycle after each access
// Notes:   phase checks are relative, so the divider reset offset need not be known
`timescale 1ns/1ps
`default_nettype none
module multi_device_sync_control_tb
  import sync_ctrl_pkg::*;
;
  logic        clk_sys, resetn, reg_wr, reg_rd, rd_d = 1'b0;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [2:0]  fire;
  logic [15:0] data_base, data_in, data_out, note, prev;
  logic        input_strobe, sync_in, output_strobe, data_valid;
  logic        alarm, irq, clkdiv_tick, pll_strobe;
  logic [15:0] q[$];
  int          num_errors = 0, comparisons = 0, cycles = 0, seed, g, k1, k2;
  logic [3:0]  ra [6] = '{4'h0, 4'h2, 4'h3, 4'h6, 4'h7, 4'ha};
  logic [7:0]  rv [6] = '{MAIN_RESET, PLL_RESET, SEL_RESET, ZERO8, FIFO_OFS_RST, ZERO8};
  logic [7:0]  tm [5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h04};
  logic [7:0]  ts [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  int          tp [5] = '{0, 2, 0, 1, 2};
  multi_device_sync_control i_multi_device_sync_control (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .input_strobe(input_strobe), .sync_in(sync_in),
    .output_strobe(output_strobe), .data_valid(data_valid), .data_in(data_in),
    .data_out(data_out), .alarm(alarm), .irq(irq), .clkdiv_tick(clkdiv_tick),
    .pll_strobe(pll_strobe));
  sync_source_model i_sync_source_model (.clk_sys(clk_sys), .resetn(resetn), .fire(fire),
    .data_base(data_base), .input_strobe(input_strobe), .sync_in(sync_in),
    .output_strobe(output_strobe), .data_valid(data_valid), .data_in(data_in));
  // free-running 20 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  // read notes the masked expectation; the monitor compares the answer
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    q.push_back({m, e});
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic pulse(input int w);
    fire <= 3'(1 << w);
    @(posedge clk_sys);
    fire <= 3'h0;
    @(posedge clk_sys);
  endtask
  // cycles from a settled point after a pulse to the next divider or strobe pulse
  task automatic phase(input int w, input bit pll, output int k);
    pulse(w);
    repeat (10) @(posedge clk_sys);
    k = 0;
    while ((pll ? pll_strobe : clkdiv_tick) !== 1'b1 && k < 16)
    begin
      @(posedge clk_sys);
      k++;
    end
  endtask
  // read answers stand only in the cycle after the strobe
  always @(posedge clk_sys)
  begin
    rd_d <= reg_rd;
    if (rd_d)
    begin
      note = q.pop_front();
      check(16'(reg_rdata & note[15:8]), 16'(note[7:0]));
    end
  end
  // hang guard, well above the length of the sequence
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    {resetn, reg_wr, reg_rd, fire, reg_addr, reg_wdata} <= '0;
    seed = $urandom(20);
    data_base = 16'($urandom);
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 6; i++)
      rd(ra[i], rv[i], 8'hff);
    $display("test reset values done");
    g = $urandom_range(1, 20);
    phase(2, 1'b0, k1);
    repeat (g) @(posedge clk_sys);
    phase(2, 1'b0, k2);
    check(16'(k2), 16'(k1));
    wr(ADDR_MAIN_CTRL, 8'h01);
    phase(2, 1'b0, k1);
    repeat (g) @(posedge clk_sys);
    phase(2, 1'b0, k2);
    check(16'(k2), 16'(((-12 - g) % CLKDIV_DEF + CLKDIV_DEF) % CLKDIV_DEF));
    $display("test divider sync done");
    for (int i = 0; i < 5; i++)
    begin
      wr(ADDR_MAIN_CTRL, tm[i]);
      wr(ADDR_SYNC_SEL, ts[i]);
      wr(ADDR_IRQ_CLR, 8'hff);
      pulse(tp[i]);
      repeat (10) @(posedge clk_sys);
      rd(ADDR_IRQ_STAT, (i % 4) ? 8'h10 : 8'h00, 8'h10);
    end
    $display("test pointer sources done");
    wr(ADDR_MAIN_CTRL, 8'h00);
    wr(ADDR_IRQ_EN, 8'h10);
    wr(ADDR_IRQ_CLR, 8'hff);
    pulse(0);
    repeat (10) @(posedge clk_sys);
    check(16'(irq), 16'h0001);
    wr(ADDR_IRQ_CLR, 8'h10);
    check(16'(irq), 16'h0000);
    wr(ADDR_IRQ_EN, 8'h00);
    pulse(0);
    repeat (10) @(posedge clk_sys);
    check(16'(irq), 16'h0000);
    rd(ADDR_IRQ_STAT, 8'h10, 8'h10);
    $display("test interrupt done");
    wr(ADDR_MAIN_CTRL, 8'h01);
    // output strobe trails input strobe by two cycles: offset 6 puts read on write
    wr(ADDR_FIFO_OFS, 8'h06);
    pulse(0);
    pulse(2);
    repeat (10) @(posedge clk_sys);
    rd(ADDR_ALARM_STAT, 8'h01, 8'h01);
    check(16'(alarm), 16'h0001);
    // offset 2 plus the two-cycle strobe lag leaves the pointers half the fifo apart
    wr(ADDR_FIFO_OFS, 8'h02);
    pulse(0);
    pulse(2);
    repeat (10) @(posedge clk_sys);
    rd(ADDR_ALARM_STAT, 8'h00, 8'h07);
    check(16'(alarm), 16'h0000);
    prev = data_out;
    repeat (16)
    begin
      @(posedge clk_sys);
      check(data_out, prev + 16'h0001);
      prev = data_out;
    end
    $display("test alarms and latency done");
    wr(ADDR_MAIN_CTRL, 8'h07);
    wr(ADDR_PLL_CTRL, 8'h01);
    wr(ADDR_IRQ_CLR, 8'hff);
    phase(1, 1'b1, k1);
    rd(ADDR_IRQ_STAT, 8'h08, 8'h08);
    repeat (g) @(posedge clk_sys);
    phase(1, 1'b1, k2);
    check(16'(k2), 16'(k1));
    wr(ADDR_PLL_CTRL, 8'h00);
    phase(1, 1'b1, k1);
    repeat (g) @(posedge clk_sys);
    phase(1, 1'b1, k2);
    check(16'(k2), 16'(((-12 - g) % NDIV_DEF + NDIV_DEF) % NDIV_DEF));
    wr(ADDR_MAIN_CTRL, 8'h05);
    $display("test pll sync done");
    repeat (4) @(posedge clk_sys);
    end_sim();
  end
endmodule // multi_device_sync_control_tb
`default_nettype wire
